// >>> include/srwd_pkg.sv
// constants shared by the system reset and watchdog block
package srwd_pkg;
    localparam int SYS_CLK_HZ = 125_000_000;
    // nominal watchdog oscillator rate
    localparam int WDT_OSC_HZ = 1_000_000;
    localparam int WDT_TICK_DIV = SYS_CLK_HZ / WDT_OSC_HZ;
    localparam int TICK_CNT_W = 8;
    localparam int WDT_BASE_TICKS = 16384;
    localparam int WDT_CNT_W = 22;
    localparam int PRESCALE_W = 3;
    localparam int STARTUP_BASE_CYC = 1024;
    localparam int STARTUP_CNT_W = 16;
    localparam int LEN_SEL_W = 2;
    localparam int CLK_SEL_W = 4;
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [1:0] UNLOCK_LAST = 2'(UNLOCK_CYCLES - 1);
    localparam int SETTLE_W = 2;
    localparam logic [1:0] SETTLE_INIT = 2'h3;

    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_RESET_CAUSE = 4'h0;
    localparam logic [3:0] OFS_WDT_CTRL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    localparam int POWER_ON_FLAG_BIT = 0;
    localparam int EXT_PIN_FLAG_BIT = 1;
    localparam int BROWNOUT_FLAG_BIT = 2;
    localparam int WDT_FLAG_BIT = 3;
    localparam int TEST_PORT_FLAG_BIT = 4;
    localparam logic [4:0] CAUSE_RESET = 5'h01;

    localparam int PRESCALE_LSB = 0;
    localparam int ENABLE_BIT = 3;
    localparam int UNLOCK_BIT = 4;

    localparam int STAT_VREF_BIT = 0;
    localparam int STAT_RESET_BIT = 1;
    localparam int STAT_SRC_BIT = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [7:0] srwd_byte_t;
endpackage

// >>> include/srwd_wdt_if.sv
// link between the reset controller and its watchdog timer
`timescale 1ns/1ps
interface srwd_wdt_if;
    import srwd_pkg::*;
    logic tick;
    logic enable;
    logic restart;
    logic clear;
    logic [PRESCALE_W-1:0] prescale;
    logic expire;
    modport ctrl (output tick, output enable, output restart, output clear,
        output prescale, input expire);
    modport timer (input tick, input enable, input restart, input clear,
        input prescale, output expire);
endinterface

// >>> logic/srwd_watchdog.sv
// watchdog counter running on the oscillator tick enable
`timescale 1ns/1ps
module srwd_watchdog #(
    parameter int BASE_TICKS = srwd_pkg::WDT_BASE_TICKS
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    srwd_wdt_if.timer wdt
);
    import srwd_pkg::*;

    logic [WDT_CNT_W-1:0] count_reg;
    logic [WDT_CNT_W-1:0] limit;
    logic expire_reg;

    // time-out doubles with each prescale code
    assign limit = WDT_CNT_W'(BASE_TICKS) << wdt.prescale;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= 1'b0;
            if (wdt.clear || wdt.restart || !wdt.enable) begin
                count_reg <= '0;
            end else if (wdt.tick) begin
                if (count_reg == limit - 1'b1) begin
                    count_reg <= '0;
                    expire_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

    assign wdt.expire = expire_reg;
endmodule

// >>> logic/srwd_startup_delay.sv
// start-up delay counter that stretches the internal reset
`timescale 1ns/1ps
module srwd_startup_delay #(
    parameter int BASE_CYC = srwd_pkg::STARTUP_BASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic srcActive,
    input wire logic [srwd_pkg::LEN_SEL_W-1:0] lengthSel,
    output logic stretched
);
    import srwd_pkg::*;

    logic [STARTUP_CNT_W-1:0] count_reg;
    logic [STARTUP_CNT_W-1:0] length;

    assign length = STARTUP_CNT_W'(BASE_CYC) << lengthSel;

    // reload while any source is active, count only once all are gone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
            stretched <= 1'b1;
        end else if (srcActive) begin
            count_reg <= length;
            stretched <= 1'b1;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
            stretched <= 1'b1;
        end else begin
            stretched <= 1'b0;
        end
    end
endmodule

// >>> logic/srwd_top.sv
// system reset controller with reset-cause flags and watchdog
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

// How it works
// - during reset watchdog control registers take initial values; a fetch pulse marks reset end
// - port-reset output rises asynchronously when any pin-level source goes active
// - internal reset stays high until the delay counter expires after sources drop
// - five sources: power-on, pin, watchdog, brown-out, test-port register
// - core held in reset while the test-port reset bit is one
// - supply good starts delay; supply loss reasserts reset at once
// - low reset pin resets without clock; release waits for delay counter
// - enabled brown-out resets at once; recovery waits for delay counter
// - watchdog expiry gives one-clock pulse; delay starts after its fall
// - reference on when brown-out, comparator bandgap or converter enabled
// - watchdog counts ticks of a nominal 1 MHz oscillator
// - watchdog counter cleared on restart, disable and chip reset
// - bit 4 flags test-port reset; cleared by power-on or written zero
// - bit 3 flags watchdog reset; cleared by power-on or written zero
// - bit 2 flags brown-out reset; cleared by power-on or written zero
// - bit 1 flags pin reset; cleared by power-on or written zero
// - bit 0 flags power-on; only a written zero clears it
// - watchdog control bits 7 to 5 always read zero
// - unlock bit clears itself four clocks after being written one
// - enable sets on written one; clears on core reset, or by write only while unlock reads one
// - prescale code selects 16384 doubling up to 2097152 oscillator cycles
module srwd_top #(
    parameter int WDT_BASE_TICKS = srwd_pkg::WDT_BASE_TICKS,
    parameter int STARTUP_BASE_CYC = srwd_pkg::STARTUP_BASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic powerGood,
    input wire logic resetPin_n,
    input wire logic brownoutLow,
    input wire logic brownoutEnableFuse,
    input wire logic testPortCoreReset,
    input wire logic [srwd_pkg::CLK_SEL_W-1:0] clockSelectFuses,
    input wire logic comparatorBandgapSelect,
    input wire logic converterEnable,
    input wire logic watchdogRestart,
    input wire logic [srwd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [srwd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic portReset,
    output logic coreReset,
    output logic resetVectorFetch,
    output logic vrefEnable
);
    import srwd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // decoding shared by read and write paths

    function automatic logic isCause(input logic [ADDR_W-1:0] a);
        return a == OFS_RESET_CAUSE;
    endfunction

    function automatic logic isWdtCtrl(input logic [ADDR_W-1:0] a);
        return a == OFS_WDT_CTRL;
    endfunction

    function automatic logic isStatus(input logic [ADDR_W-1:0] a);
        return a == OFS_STATUS;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [8:0] syncA_reg;
    logic [8:0] syncB_reg;
    logic porActive;
    logic pinActive;
    logic sagLow;
    logic sagFuse;
    logic testReset;
    logic [CLK_SEL_W-1:0] clkSelSync;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {clockSelectFuses, testPortCoreReset,
                brownoutEnableFuse, brownoutLow, ~resetPin_n, ~powerGood};
            syncB_reg <= syncA_reg;
        end
    end

    assign porActive = syncB_reg[0];
    assign pinActive = syncB_reg[1];
    assign sagLow = syncB_reg[2];
    assign sagFuse = syncB_reg[3];
    assign testReset = syncB_reg[4];
    assign clkSelSync = syncB_reg[8:5];

    ////////////////////////////////////////////////////////////////////
    // reset source combination

    logic [SETTLE_W-1:0] settle_reg;
    logic sagReset;
    logic srcActive;
    logic stretched;
    logic asyncHold_n;
    srwd_wdt_if wdt ();

    // covers the synchroniser latency right after power-up
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            settle_reg <= SETTLE_INIT;
        end else begin
            settle_reg <= settle_reg >> 1;
        end
    end

    assign sagReset = sagFuse && sagLow;
    assign srcActive = settle_reg[0] || porActive || pinActive
        || sagReset || testReset || wdt.expire;

    // raw pin levels: acts with no clock running, may glitch on pin noise
    assign asyncHold_n = reset_n && powerGood && resetPin_n
        && !(brownoutEnableFuse && brownoutLow)
        && !testPortCoreReset;

    srwd_startup_delay #(
        .BASE_CYC(STARTUP_BASE_CYC)
    ) u_delay (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .srcActive(srcActive),
        .lengthSel(clkSelSync[LEN_SEL_W-1:0]),
        .stretched(stretched)
    );

    // asynchronous set, synchronous release after the stretch
    always_ff @(posedge clk_sys or negedge asyncHold_n) begin
        if (!asyncHold_n) begin
            portReset <= 1'b1;
        end else begin
            portReset <= stretched;
        end
    end

    always_ff @(posedge clk_sys or negedge asyncHold_n) begin
        if (!asyncHold_n) begin
            coreReset <= 1'b1;
        end else begin
            coreReset <= stretched;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resetVectorFetch <= 1'b0;
        end else begin
            resetVectorFetch <= coreReset && !stretched;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            vrefEnable <= 1'b0;
        end else begin
            vrefEnable <= sagFuse || comparatorBandgapSelect
                || converterEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog oscillator tick

    logic [TICK_CNT_W-1:0] tickDiv_reg;
    logic tick_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tickDiv_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tickDiv_reg == TICK_CNT_W'(WDT_TICK_DIV - 1)) begin
            tickDiv_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tickDiv_reg <= tickDiv_reg + 1'b1;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write channel

    logic awHeld_reg;
    logic wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [7:0] wByte_reg;
    logic wLane_reg;
    logic doWrite;
    logic wrCause;
    logic wrWdt;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awHeld_reg <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wHeld_reg <= 1'b0;
            wByte_reg <= '0;
            wLane_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wByte_reg <= s_axi_wdata[7:0];
            wLane_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wHeld_reg <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrCause = doWrite && wLane_reg && isCause(awAddr_reg);
    assign wrWdt = doWrite && wLane_reg && isWdtCtrl(awAddr_reg);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (isCause(awAddr_reg) || isWdtCtrl(awAddr_reg)
                || isStatus(awAddr_reg)) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset-cause flags, kept through every reset except power-on

    logic [4:0] cause_reg;
    logic [4:0] cause_next;
    logic [4:0] causeSet;

    assign causeSet = {testReset, wdt.expire, sagReset, pinActive, porActive};

    always_comb begin
        cause_next = cause_reg;
        if (wrCause) begin
            cause_next = cause_reg & wByte_reg[4:0];
        end
        if (porActive) begin
            cause_next[TEST_PORT_FLAG_BIT] = 1'b0;
            cause_next[WDT_FLAG_BIT] = 1'b0;
            cause_next[BROWNOUT_FLAG_BIT] = 1'b0;
            cause_next[EXT_PIN_FLAG_BIT] = 1'b0;
        end
        // a hardware set wins over a simultaneous software clear
        cause_next = cause_next | causeSet;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cause_reg <= CAUSE_RESET;
        end else begin
            cause_reg <= cause_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog control

    logic unlock_reg;
    logic [1:0] unlockCnt_reg;
    logic wdtEnable_reg;
    logic [PRESCALE_W-1:0] prescale_reg;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            unlock_reg <= 1'b0;
            unlockCnt_reg <= '0;
        end else if (coreReset) begin
            unlock_reg <= 1'b0;
            unlockCnt_reg <= '0;
        end else if (wrWdt && wByte_reg[UNLOCK_BIT]) begin
            unlock_reg <= 1'b1;
            unlockCnt_reg <= UNLOCK_LAST;
        end else if (unlock_reg) begin
            if (unlockCnt_reg == '0) begin
                unlock_reg <= 1'b0;
            end else begin
                unlockCnt_reg <= unlockCnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wdtEnable_reg <= 1'b0;
            prescale_reg <= '0;
        end else if (coreReset) begin
            wdtEnable_reg <= 1'b0;
            prescale_reg <= '0;
        end else if (wrWdt) begin
            prescale_reg <= wByte_reg[PRESCALE_LSB +: PRESCALE_W];
            if (wByte_reg[ENABLE_BIT]) begin
                wdtEnable_reg <= 1'b1;
            end else if (unlock_reg) begin
                // clear window opened by the earlier unlock write
                wdtEnable_reg <= 1'b0;
            end
        end
    end

    assign wdt.tick = tick_reg;
    assign wdt.enable = wdtEnable_reg;
    assign wdt.restart = watchdogRestart;
    assign wdt.clear = coreReset;
    assign wdt.prescale = prescale_reg;

    srwd_watchdog #(
        .BASE_TICKS(WDT_BASE_TICKS)
    ) u_wdt (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wdt(wdt)
    );

    ////////////////////////////////////////////////////////////////////
    // read channel

    srwd_byte_t rdByte;

    always_comb begin
        rdByte = '0;
        if (isCause(s_axi_araddr)) begin
            rdByte = {3'h0, cause_reg};
        end else if (isWdtCtrl(s_axi_araddr)) begin
            rdByte = {3'h0, unlock_reg, wdtEnable_reg, prescale_reg};
        end else if (isStatus(s_axi_araddr)) begin
            rdByte[STAT_VREF_BIT] = vrefEnable;
            rdByte[STAT_RESET_BIT] = coreReset;
            rdByte[STAT_SRC_BIT] = srcActive;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rdByte};
            if (isCause(s_axi_araddr) || isWdtCtrl(s_axi_araddr)
                || isStatus(s_axi_araddr)) begin
                s_axi_rresp <= RESP_OKAY;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// >>> testbench/srwd_top_props.sv
// port-level assertions for the reset controller
`timescale 1ns/1ps
module srwd_top_props #(
    parameter int STARTUP_BASE_CYC = srwd_pkg::STARTUP_BASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic powerGood,
    input wire logic resetPin_n,
    input wire logic brownoutLow,
    input wire logic brownoutEnableFuse,
    input wire logic testPortCoreReset,
    input wire logic [srwd_pkg::CLK_SEL_W-1:0] clockSelectFuses,
    input wire logic comparatorBandgapSelect,
    input wire logic converterEnable,
    input wire logic [srwd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic portReset,
    input wire logic coreReset,
    input wire logic resetVectorFetch,
    input wire logic vrefEnable
);
    import srwd_pkg::*;
    logic [11:0] quietCnt_reg;
    logic srcOn;
    int dly;
    assign srcOn = !powerGood || !resetPin_n || testPortCoreReset
        || (brownoutEnableFuse && brownoutLow);
    assign dly = STARTUP_BASE_CYC << clockSelectFuses[1:0];
    // cycles since the last active source, saturating so it never wraps
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            quietCnt_reg <= 12'h0;
        end else if (srcOn) begin
            quietCnt_reg <= 12'h0;
        end else if (quietCnt_reg != 12'hfff) begin
            quietCnt_reg <= quietCnt_reg + 12'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    fetch_pulse_a: assert property ($fell(coreReset) |-> ##[0:1] resetVectorFetch ##1 !resetVectorFetch)
        else $error("fetch pulse missing after reset end");
    pin_hold_a: assert property (!resetPin_n |-> portReset && coreReset)
        else $error("pin low without reset");
    src_hold_a: assert property ((!powerGood || testPortCoreReset || brownoutEnableFuse && brownoutLow) |-> portReset && coreReset)
        else $error("active source without reset");
    stretch_min_a: assert property ($fell(coreReset) |-> quietCnt_reg >= dly)
        else $error("reset released before delay");
    stretch_max_a: assert property (quietCnt_reg == dly + 24 |-> !coreReset)
        else $error("reset held past delay");
    vref_on_a: assert property ((comparatorBandgapSelect || converterEnable) |=> vrefEnable)
        else $error("reference off while requested");
    vref_off_a: assert property ((!brownoutEnableFuse && !comparatorBandgapSelect && !converterEnable) [*4] |=> !vrefEnable)
        else $error("reference on without request");
    wdt_rsvd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_WDT_CTRL |=> s_axi_rdata[7:5] == 3'h0)
        else $error("reserved control bits not zero");
    cover property ($fell(coreReset));
    cover property (!resetPin_n ##1 resetPin_n);
    cover property (vrefEnable && !brownoutEnableFuse);
endmodule

bind srwd_top srwd_top_props #(.STARTUP_BASE_CYC(STARTUP_BASE_CYC)) u_props (.*);

// >>> testbench/srwd_supply_model.sv
// supply detectors and reset pin as seen from outside the block
`timescale 1ns/1ps
module srwd_supply_model (
    input wire logic supplyOff,
    input wire logic pinHeld,
    input wire logic supplySag,
    input wire logic scanHold,
    output logic powerGood,
    output logic resetPin_n,
    output logic brownoutLow,
    output logic testPortCoreReset
);
    // plain levels, no filtering: glitches reach the block unsoftened
    assign powerGood = !supplyOff;
    assign resetPin_n = !pinHeld;
    assign brownoutLow = supplySag;
    assign testPortCoreReset = scanHold;
endmodule

// >>> testbench/srwd_top_tb_top.sv
// self-checking bench for the reset controller and watchdog
`timescale 1ns/1ps
module srwd_top_tb_top;
    import srwd_pkg::*;
    localparam int SB = 8;
    localparam int WB = 4;
    logic clk_sys = 1'h0, reset_n = 1'h0, watchdogRestart = 1'h0;
    logic supplyOff = 1'h0, pinHeld = 1'h0, supplySag = 1'h0, scanHold = 1'h0;
    logic brownoutEnableFuse = 1'h0, comparatorBandgapSelect = 1'h0, converterEnable = 1'h0;
    logic [3:0] clockSelectFuses = 4'h0, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    // answers are always accepted at once
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic powerGood, resetPin_n, brownoutLow, testPortCoreReset;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic portReset, coreReset, resetVectorFetch, vrefEnable;
    logic [7:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;
    srwd_supply_model u_supply (.*);
    srwd_top #(.WDT_BASE_TICKS(WB), .STARTUP_BASE_CYC(SB)) u_dut (.*);
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] want);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata[7:0];
        rs = s_axi_rresp;
        chk(rd, want);
    endtask
    task automatic waitcr(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (coreReset !== v && n <= hi) begin
            @(posedge clk_sys);
            n++;
        end
        comparisons++;
        if (n < lo || n > hi) begin
            n_mismatch++;
            $display("BAD %0t reset level after %0d cycles", $time, n);
        end
        if (v == 1'h0) begin
            chk(8'(resetVectorFetch), 8'h01);
            @(posedge clk_sys);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_src;
        // power-on flag survives the other sources, power-on clears theirs
        logic [7:0] cause [4] = '{8'h03, 8'h07, 8'h17, 8'h01};
        supplySag <= 1'h1;
        repeat (20) @(posedge clk_sys);
        chk(8'(coreReset), 8'h00);
        for (int i = 0; i < 4; i++) begin
            clockSelectFuses <= 4'(i);
            pinHeld <= (i == 0);
            brownoutEnableFuse <= (i == 1);
            supplySag <= (i == 1);
            scanHold <= (i == 2);
            supplyOff <= (i == 3);
            #1 chk({6'h0, portReset, coreReset}, 8'h03);
            repeat (30) @(posedge clk_sys);
            chk(8'(coreReset), 8'h01);
            rchk(OFS_STATUS, 8'(6 + (i == 1)));
            pinHeld <= 1'h0;
            supplySag <= 1'h0;
            scanHold <= 1'h0;
            supplyOff <= 1'h0;
            waitcr(1'h0, SB << i, (SB << i) + 24);
            rchk(OFS_RESET_CAUSE, cause[i]);
        end
        brownoutEnableFuse <= 1'h0;
        clockSelectFuses <= 4'h0;
    endtask
    task automatic t_regs;
        rchk(OFS_RESET_CAUSE, 8'h01);
        wr(OFS_RESET_CAUSE, 8'h1f);
        chk(8'(rs), 8'(RESP_OKAY));
        rchk(OFS_RESET_CAUSE, 8'h01);
        s_axi_wstrb <= 4'h0;
        wr(OFS_RESET_CAUSE, 8'h00);
        s_axi_wstrb <= 4'h1;
        rchk(OFS_RESET_CAUSE, 8'h01);
        wr(OFS_RESET_CAUSE, 8'h00);
        rchk(OFS_RESET_CAUSE, 8'h00);
        wr(OFS_WDT_CTRL, 8'he8);
        rchk(OFS_WDT_CTRL, 8'h08);
        wr(OFS_WDT_CTRL, 8'h00);
        rchk(OFS_WDT_CTRL, 8'h08);
        wr(OFS_WDT_CTRL, 8'h18);
        repeat (6) @(posedge clk_sys);
        wr(OFS_WDT_CTRL, 8'h00);
        rchk(OFS_WDT_CTRL, 8'h08);
        wr(OFS_WDT_CTRL, 8'h18);
        wr(OFS_WDT_CTRL, 8'h00);
        rchk(OFS_WDT_CTRL, 8'h00);
        wr(OFS_WDT_CTRL, 8'h10);
        rchk(OFS_WDT_CTRL, 8'h10);
        repeat (4) @(posedge clk_sys);
        rchk(OFS_WDT_CTRL, 8'h00);
        wr(4'hc, 8'hff);
        chk(8'(rs), 8'(RESP_SLVERR));
        rchk(4'hc, 8'h00);
        chk(8'(rs), 8'(RESP_SLVERR));
    endtask
    task automatic t_vref;
        for (int k = 0; k < 8; k++) begin
            {brownoutEnableFuse, comparatorBandgapSelect, converterEnable} <= 3'(k);
            repeat (5) @(posedge clk_sys);
            chk(8'(vrefEnable), 8'(k != 0));
        end
        {brownoutEnableFuse, comparatorBandgapSelect, converterEnable} <= 3'h0;
    endtask
    task automatic t_wdt;
        int per;
        for (int p = 0; p < 2; p++) begin
            per = (WB << p) * WDT_TICK_DIV;
            wr(OFS_WDT_CTRL, 8'(8'h08 | p));
            // restarts well inside the period must keep the core running
            repeat (3) begin
                repeat (per - 150) @(posedge clk_sys);
                watchdogRestart <= 1'h1;
                @(posedge clk_sys);
                watchdogRestart <= 1'h0;
            end
            chk(8'(coreReset), 8'h00);
            waitcr(1'h1, per - WDT_TICK_DIV - 2, per + 8);
            waitcr(1'h0, SB, SB + 24);
            rchk(OFS_RESET_CAUSE, 8'h08);
            wr(OFS_RESET_CAUSE, 8'h00);
            rchk(OFS_WDT_CTRL, 8'h00);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'h1;
        waitcr(1'h0, SB, SB + 24);
        t_src;
        t_regs;
        t_vref;
        t_wdt;
        complete_run;
    end
    // the sequence needs under 10000 cycles; this is 25000 cycles, two and a half times that
    initial begin
        #200us;
        n_mismatch++;
        complete_run;
    end
endmodule
